/* File: ets_pkg.sv */
// Constants and types shared by the error and thermal signalling block.
package ets_pkg;
  localparam int unsigned ETS_CLK_HZ = 125000000;
  localparam int unsigned ETS_MCE_PULSE_CYC = 16;
  localparam logic [4:0] ETS_MCE_CNT_RST = 5'h00;
  localparam logic [7:0] ETS_TRIP_DEG_C = 8'h82;
  localparam logic [7:0] ETS_TEMP_RST = 8'h00;
  localparam int unsigned ETS_PWR_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ETS_ERR_IDLE = 2'b00,
    ETS_ERR_PULSE = 2'b01,
    ETS_ERR_HOLD = 2'b10
  } ets_err_state_t;
endpackage

/* File: ets_sync.sv */
// Two-stage synchroniser for asynchronous level inputs.
module ets_sync
  import ets_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic d_async,
  output logic q_sync
);
  logic meta_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta_r <= RST_VAL;
      q_sync <= RST_VAL;
    end else begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end
endmodule

/* File: ets_top.sv */
// Error and thermal signalling toward platform logic.
module ets_top
  import ets_pkg::*;
#(
  parameter int unsigned TEMP_W = 8,
  parameter logic [TEMP_W-1:0] TRIP_DEG = TEMP_W'(ETS_TRIP_DEG_C)
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic warm_rst,
  input wire logic power_stable,
  input wire logic machine_check_error,
  input wire logic internal_error,
  input wire logic [TEMP_W-1:0] junction_temp,
  input wire logic temp_at_max,
  input wire logic throttle_enable,
  input wire logic overtemp_n_in,
  output logic fatal_error_n,
  output logic overtemp_n_out,
  output logic overtemp_n_oe_n,
  output logic thermal_throttle_circuit,
  output logic thermal_shutdown_n,
  output logic exec_halt
);
  logic pwr_ok;
  logic ext_hot_n;
  logic run;
  ets_err_state_t err_state_r;
  ets_err_state_t err_state_nxt;
  logic [4:0] pulse_cnt_r;
  logic hot_r;
  logic trip_r;

  // Power stable is asynchronous, so it is synchronised before use.
  ets_sync #(.RST_VAL(1'b0)) u_pwr_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d_async(power_stable),
    .q_sync(pwr_ok)
  );

  // The overtemp line is shared, so its level is synchronised like a pin.
  ets_sync #(.RST_VAL(1'b1)) u_hot_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .d_async(overtemp_n_in),
    .q_sync(ext_hot_n)
  );

  // Warm reset clears error state just like the power-down hold.
  assign run = pwr_ok && !warm_rst;

  always_comb begin
    err_state_nxt = err_state_r;
    case (err_state_r)
      ETS_ERR_IDLE: begin
        if (internal_error) begin
          err_state_nxt = ETS_ERR_HOLD;
        end else if (machine_check_error) begin
          err_state_nxt = ETS_ERR_PULSE;
        end
      end
      ETS_ERR_PULSE: begin
        if (internal_error) begin
          err_state_nxt = ETS_ERR_HOLD;
        end else if (pulse_cnt_r == 5'(ETS_MCE_PULSE_CYC - 1)) begin
          err_state_nxt = ETS_ERR_IDLE;
        end
      end
      ETS_ERR_HOLD: begin
        err_state_nxt = ETS_ERR_HOLD;
      end
      default: begin
        err_state_nxt = ETS_ERR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      err_state_r <= ETS_ERR_IDLE;
    end else if (!run) begin
      err_state_r <= ETS_ERR_IDLE;
    end else begin
      err_state_r <= err_state_nxt;
    end
  end

  // A machine check during an active pulse does not restart it.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt_r <= ETS_MCE_CNT_RST;
    end else if (!run || err_state_r != ETS_ERR_PULSE) begin
      pulse_cnt_r <= ETS_MCE_CNT_RST;
    end else begin
      pulse_cnt_r <= pulse_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fatal_error_n <= 1'b1;
    end else if (!run) begin
      fatal_error_n <= 1'b1;
    end else begin
      fatal_error_n <= !(err_state_nxt != ETS_ERR_IDLE);
    end
  end

  // Overtemp only reports when throttling is enabled and engaged.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hot_r <= 1'b0;
    end else if (!pwr_ok) begin
      hot_r <= 1'b0;
    end else begin
      hot_r <= temp_at_max && throttle_enable;
    end
  end

  // Open-drain: enable low drives the line low, otherwise released.
  assign overtemp_n_out = 1'b0;
  assign overtemp_n_oe_n = !hot_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      thermal_throttle_circuit <= 1'b0;
    end else if (!pwr_ok) begin
      thermal_throttle_circuit <= 1'b0;
    end else begin
      thermal_throttle_circuit <= hot_r || !ext_hot_n;
    end
  end

  // The trip latches until power stable drops; cooling alone must not restart.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trip_r <= 1'b0;
    end else if (!pwr_ok) begin
      trip_r <= 1'b0;
    end else if (junction_temp > TRIP_DEG) begin
      trip_r <= 1'b1;
    end
  end

  assign thermal_shutdown_n = !trip_r;
  assign exec_halt = trip_r;
endmodule

/* File: ets_checker.sv */
// Port assertions for the error and thermal block.
module ets_checker
  import ets_pkg::*;
(
  input logic clk_sys,
  input logic rstn,
  input logic warm_rst,
  input logic power_stable,
  input logic fatal_error_n,
  input logic machine_check_error,
  input logic internal_error,
  input logic [7:0] junction_temp,
  input logic temp_at_max,
  input logic throttle_enable,
  input logic overtemp_n_in,
  input logic overtemp_n_oe_n,
  input logic thermal_throttle_circuit,
  input logic thermal_shutdown_n,
  input logic exec_halt
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // A power drop or warm reset legally cuts the pulse short; an internal error holds it low.
  property p_len;
    disable iff (!rstn || !power_stable || warm_rst || internal_error)
    $fell(fatal_error_n) && $past(machine_check_error) |->
      !fatal_error_n [*8] ##1 !fatal_error_n [*8] ##1 fatal_error_n;
  endproperty
  a_len: assert property (p_len) else $error("bad pulse length");
  property p_off; !power_stable [*4] |-> fatal_error_n; endproperty
  a_off: assert property (p_off) else $error("fatal while unpowered");
  property p_internal_error;
    disable iff (!rstn || !power_stable)
    internal_error && !warm_rst |=> !fatal_error_n;
  endproperty
  a_internal_error: assert property (p_internal_error) else $error("internal error not held");
  property p_hot;
    disable iff (!rstn || !power_stable)
    temp_at_max && throttle_enable |=> !overtemp_n_oe_n;
  endproperty
  a_hot: assert property (p_hot) else $error("overtemp not driven");
  property p_cool; !throttle_enable |=> overtemp_n_oe_n; endproperty
  a_cool: assert property (p_cool) else $error("overtemp while disabled");
  property p_ext;
    disable iff (!rstn || !power_stable)
    !overtemp_n_in |-> ##3 thermal_throttle_circuit;
  endproperty
  a_ext: assert property (p_ext) else $error("external overtemp ignored");
  property p_trip;
    disable iff (!rstn || !power_stable)
    junction_temp > ETS_TRIP_DEG_C |=> !thermal_shutdown_n && exec_halt;
  endproperty
  a_trip: assert property (p_trip) else $error("no thermal shutdown");
endmodule
bind ets_top ets_checker u_chk (.*);

/* File: ets_platform.sv */
// Platform side model of the power and overtemp pins.
module ets_platform (
  input logic ok,
  input logic hot,
  input logic overtemp_n_oe_n,
  output logic power_stable,
  output logic overtemp_n_in
);
  assign power_stable = ok;
  // Pulled-up shared line: either side pulls it low, released it reads high.
  assign overtemp_n_in = !(hot || !overtemp_n_oe_n);
endmodule

/* File: testbench.sv */
// Error and thermal bench.
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %s exp %0h got %0h", n, e, a); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rstn = 0, warm_rst = 0, ok = 0, machine_check_error = 0, hot = 0;
  logic internal_error = 0, temp_at_max = 0, throttle_enable = 1;
  logic [7:0] junction_temp = 8'h00;
  logic power_stable, overtemp_n_in, overtemp_n_oe_n, overtemp_n_out, fatal_error_n;
  logic thermal_throttle_circuit, thermal_shutdown_n, exec_halt;
  int err_count = 0, comparisons = 0;
  ets_platform u_plat (.*);
  ets_top uut (.*);
  initial forever #4 clk_sys = ~clk_sys;
  task w(input int n); repeat (n) @(negedge clk_sys); endtask
  task stop_test;
    if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task t_err;
    machine_check_error = 1;
    w(1);
    machine_check_error = 0;
    `CHK("mce", 1'b0, fatal_error_n)
    w(16);
    `CHK("mce end", 1'b1, fatal_error_n)
    internal_error = 1;
    w(30);
    `CHK("internal_error", 1'b0, fatal_error_n)
    {internal_error, warm_rst} = 2'b01;
    w(1);
    warm_rst = 0;
    `CHK("warm", 1'b1, fatal_error_n)
  endtask
  task t_hot;
    throttle_enable = 0;
    temp_at_max = 1;
    w(3);
    `CHK("hot off", 1'b1, overtemp_n_oe_n)
    `CHK("thr off", 1'b0, thermal_throttle_circuit)
    throttle_enable = 1;
    w(3);
    `CHK("hot", 1'b0, overtemp_n_oe_n)
    `CHK("hot lvl", 1'b0, overtemp_n_out)
    `CHK("thr on", 1'b1, thermal_throttle_circuit)
    temp_at_max = 0;
    hot = 1;
    w(12);
    `CHK("ext", 1'b1, thermal_throttle_circuit)
    hot = 0;
  endtask
  task t_pwr;
    junction_temp = 8'h83;
    w(1);
    `CHK("trip", 1'b0, thermal_shutdown_n)
    `CHK("halt", 1'b1, exec_halt)
    {ok, junction_temp, machine_check_error} = 10'h000;
    w(4);
    `CHK("off", 1'b1, thermal_shutdown_n)
    `CHK("off halt", 1'b0, exec_halt)
  endtask
  initial begin
    w(10);
    {rstn, ok} = 2'b11;
    w(5);
    t_err;
    t_hot;
    t_pwr;
    stop_test;
  end
endmodule
